// *** rtl/pdac_pkg.sv ***
package pdac_pkg;

  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PDAC_RS_ADDR_WR = 3'h0; // Palette address, write mode
  localparam logic [2:0] PDAC_RS_PAL_DATA = 3'h1; // Palette data
  localparam logic [2:0] PDAC_RS_READ_MASK = 3'h2; // Pixel read mask
  localparam logic [2:0] PDAC_RS_ADDR_RD = 3'h3; // Palette address, read mode
  localparam logic [2:0] PDAC_RS_OVL_ADDR_WR = 3'h4; // Overlay address, write mode
  localparam logic [2:0] PDAC_RS_OVL_DATA = 3'h5; // Overlay data
  localparam logic [2:0] PDAC_RS_COMMAND = 3'h6; // Command register
  localparam logic [2:0] PDAC_RS_OVL_ADDR_RD = 3'h7; // Overlay address, read mode

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PDAC_RST_COMMAND = 8'h00; // Command register after reset
  localparam logic [7:0] PDAC_RST_READ_MASK = 8'hFF; // Read mask after reset
  localparam logic [7:0] PDAC_RST_ADDR = 8'h00; // Address register after reset
  localparam logic [1:0] PDAC_RST_PHASE = 2'h0; // Colour byte phase after reset

  // ----------------------------------------------------------------
  // Colour byte phase (counts modulo 3)
  // ----------------------------------------------------------------
  localparam logic [1:0] PDAC_PH_RED = 2'h0;
  localparam logic [1:0] PDAC_PH_GREEN = 2'h1;
  localparam logic [1:0] PDAC_PH_BLUE = 2'h2;

  // ----------------------------------------------------------------
  // Output levels and stages
  // ----------------------------------------------------------------
  localparam logic [7:0] PDAC_BLANK_CODE = 8'h00; // Code shown while blanked
  localparam int PDAC_SYNC_STAGES = 2; // Synchroniser depth for host strobes

  // Colour mode select encodings
  typedef enum logic [1:0] {
    PDAC_MODE_TC24,
    PDAC_MODE_TC15,
    PDAC_MODE_TC8,
    PDAC_MODE_PSEUDO8
  } pdac_mode_t;

endpackage

// *** rtl/pdac_host_sync.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Host strobe synchroniser with edge detection
// ------------------------------------------------------------------
module pdac_host_sync
  import pdac_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Asynchronous strobe, active low
  input wire logic i_strobe_n,
  // Synchronised level and edges
  output logic o_active,
  output logic o_fall,
  output logic o_rise
);

  logic meta_reg; // First stage, read only by second
  logic sync_reg; // Second stage
  logic last_reg; // Previous synchronised level

  // Two flip-flop synchroniser and history
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= i_strobe_n;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Strobe level and edges from synchronised copy
  assign o_active = !sync_reg;
  assign o_fall = last_reg && !sync_reg;
  assign o_rise = !last_reg && sync_reg;

endmodule

// *** rtl/pdac_core.sv ***
`timescale 1ns/10ps
module pdac_core
  import pdac_pkg::*;
#(
  parameter int ADDR_W = 8, // Palette address width
  parameter int OVL_N = 16 // Overlay slots, slot 0 reserved
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Pixel port
  input wire logic [7:0] i_red_pixel_in,
  input wire logic [7:0] i_green_pixel_in,
  input wire logic [7:0] i_blue_pixel_in,
  input wire logic [1:0] i_color_mode_select,
  input wire logic [3:0] i_overlay_select,
  input wire logic i_sync_n,
  input wire logic i_blank_n,
  // Host port
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic [2:0] i_register_select,
  input wire logic [7:0] i_host_data_bus,
  output logic [7:0] o_host_data_bus,
  output logic o_host_data_oe,
  // Colour codes toward the converters
  output logic [7:0] o_red_code,
  output logic [7:0] o_green_code,
  output logic [7:0] o_blue_code,
  output logic o_sync_on,
  // Control outputs
  output logic [7:0] o_general_control_outputs
);

  // ----------------------------------------------------------------
  // Host strobe synchronisation
  // ----------------------------------------------------------------
  logic wr_act, wr_fall, wr_rise; // Write strobe state
  logic rd_act, rd_fall, rd_rise; // Read strobe state

  pdac_host_sync u_wr_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_strobe_n(i_wr_n),
    .o_active(wr_act),
    .o_fall(wr_fall),
    .o_rise(wr_rise)
  );

  pdac_host_sync u_rd_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_strobe_n(i_rd_n),
    .o_active(rd_act),
    .o_fall(rd_fall),
    .o_rise(rd_rise)
  );

  // Data and select pins pass two flip-flops too
  logic [7:0] d_meta_reg, d_sync_reg;
  logic [2:0] rs_meta_reg, rs_sync_reg;

  // Pin synchronisers for bus and select
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      d_meta_reg <= 8'h00;
      d_sync_reg <= 8'h00;
      rs_meta_reg <= 3'h0;
      rs_sync_reg <= 3'h0;
    end else begin
      d_meta_reg <= i_host_data_bus;
      d_sync_reg <= d_meta_reg;
      rs_meta_reg <= i_register_select;
      rs_sync_reg <= rs_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Host register state
  // ----------------------------------------------------------------
  logic [2:0] rs_reg; // Select latched at strobe fall
  logic [7:0] addr_reg; // Address register
  logic [1:0] phase_reg; // Colour byte phase
  logic [7:0] hold_r_reg, hold_g_reg, hold_b_reg; // Colour holding
  logic [7:0] command_reg; // Command register
  logic [7:0] read_mask_reg; // Pixel read mask
  logic [23:0] palette_mem [2**ADDR_W]; // Palette memory
  logic [23:0] overlay_mem [OVL_N]; // Overlay colours

  // Latch the select on either strobe's falling edge
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rs_reg <= PDAC_RS_ADDR_WR;
    end else if (wr_fall || rd_fall) begin
      rs_reg <= rs_sync_reg;
    end
  end

  // Decoded write and read events
  logic wr_ev, rd_ev;
  assign wr_ev = wr_rise; // Data taken on write rise
  assign rd_ev = rd_rise; // Byte consumed at read end
  logic is_ovl; // Access targets overlay space
  assign is_ovl = rs_reg[2];
  logic [23:0] fetch_word; // Entry at current address
  assign fetch_word = is_ovl ? overlay_mem[addr_reg[3:0]] : palette_mem[addr_reg];

  // Address, phase and holding registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      addr_reg <= PDAC_RST_ADDR;
      phase_reg <= PDAC_RST_PHASE;
      hold_r_reg <= 8'h00;
      hold_g_reg <= 8'h00;
      hold_b_reg <= 8'h00;
    end else if (wr_ev) begin
      unique case (rs_reg)
        PDAC_RS_ADDR_WR, PDAC_RS_OVL_ADDR_WR: begin
          addr_reg <= d_sync_reg;
          phase_reg <= PDAC_PH_RED;
        end
        PDAC_RS_ADDR_RD, PDAC_RS_OVL_ADDR_RD: begin
          // Load holding then advance
          {hold_r_reg, hold_g_reg, hold_b_reg} <= rs_reg[2] ?
            overlay_mem[d_sync_reg[3:0]] : palette_mem[d_sync_reg];
          addr_reg <= d_sync_reg + 8'h01;
          phase_reg <= PDAC_PH_RED;
        end
        PDAC_RS_PAL_DATA, PDAC_RS_OVL_DATA: begin
          // Collect red, green, then blue
          if (phase_reg == PDAC_PH_RED) begin
            hold_r_reg <= d_sync_reg;
            phase_reg <= PDAC_PH_GREEN;
          end else if (phase_reg == PDAC_PH_GREEN) begin
            hold_g_reg <= d_sync_reg;
            phase_reg <= PDAC_PH_BLUE;
          end else begin
            hold_b_reg <= d_sync_reg;
            phase_reg <= PDAC_PH_RED;
            addr_reg <= addr_reg + 8'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (rd_ev && (rs_reg == PDAC_RS_PAL_DATA || rs_reg == PDAC_RS_OVL_DATA)) begin
      // Step the read phase; reload after blue
      if (phase_reg == PDAC_PH_BLUE) begin
        {hold_r_reg, hold_g_reg, hold_b_reg} <= fetch_word;
        addr_reg <= addr_reg + 8'h01;
        phase_reg <= PDAC_PH_RED;
      end else begin
        phase_reg <= phase_reg + 2'h1;
      end
    end
  end

  // Palette and overlay storage on the blue write
  always_ff @(posedge i_clk) begin
    if (wr_ev && phase_reg == PDAC_PH_BLUE) begin
      if (rs_reg == PDAC_RS_PAL_DATA) begin
        palette_mem[addr_reg] <= {hold_r_reg, hold_g_reg, d_sync_reg};
      end else if (rs_reg == PDAC_RS_OVL_DATA && addr_reg[3:0] != 4'h0) begin
        overlay_mem[addr_reg[3:0]] <= {hold_r_reg, hold_g_reg, d_sync_reg};
      end
    end
  end

  // Command and read mask registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      command_reg <= PDAC_RST_COMMAND;
      read_mask_reg <= PDAC_RST_READ_MASK;
    end else if (wr_ev) begin
      if (rs_reg == PDAC_RS_COMMAND) begin
        command_reg <= d_sync_reg;
      end
      if (rs_reg == PDAC_RS_READ_MASK) begin
        read_mask_reg <= d_sync_reg;
      end
    end
  end

  assign o_general_control_outputs = command_reg;

  // ----------------------------------------------------------------
  // Host read data
  // ----------------------------------------------------------------
  logic [7:0] rdata;
  always_comb begin
    unique case (rs_reg)
      PDAC_RS_ADDR_WR, PDAC_RS_ADDR_RD, PDAC_RS_OVL_ADDR_WR, PDAC_RS_OVL_ADDR_RD:
        rdata = addr_reg;
      PDAC_RS_PAL_DATA, PDAC_RS_OVL_DATA:
        rdata = (phase_reg == PDAC_PH_RED) ? hold_r_reg :
                (phase_reg == PDAC_PH_GREEN) ? hold_g_reg : hold_b_reg;
      PDAC_RS_READ_MASK:
        rdata = read_mask_reg;
      PDAC_RS_COMMAND:
        rdata = command_reg;
    endcase
  end

  // Registered read data, bus driven only while read is low
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_host_data_bus <= 8'h00;
      o_host_data_oe <= 1'b0;
    end else begin
      o_host_data_bus <= rdata;
      o_host_data_oe <= rd_act && !rd_fall;
    end
  end

  // ----------------------------------------------------------------
  // Pixel path: input register stage
  // ----------------------------------------------------------------
  logic [7:0] px_r_reg, px_g_reg, px_b_reg;
  logic [1:0] px_mode_reg;
  logic [3:0] px_ovl_reg;
  logic px_sync_n_reg, px_blank_n_reg;

  // Register all pixel port inputs together
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      px_r_reg <= 8'h00;
      px_g_reg <= 8'h00;
      px_b_reg <= 8'h00;
      px_mode_reg <= 2'h0;
      px_ovl_reg <= 4'h0;
      px_sync_n_reg <= 1'b1;
      px_blank_n_reg <= 1'b0;
    end else begin
      px_r_reg <= i_red_pixel_in;
      px_g_reg <= i_green_pixel_in;
      px_b_reg <= i_blue_pixel_in;
      px_mode_reg <= i_color_mode_select;
      px_ovl_reg <= i_overlay_select;
      px_sync_n_reg <= i_sync_n;
      px_blank_n_reg <= i_blank_n;
    end
  end

  // Palette look-up by index
  function automatic logic [7:0] pal_chan(input logic [7:0] idx, input int ch);
    logic [23:0] w;
    w = palette_mem[idx & read_mask_reg];
    return w[23 - 8*ch -: 8];
  endfunction

  // Colour source selection per pixel
  logic [23:0] colour;
  always_comb begin
    colour = 24'h00_0000;
    if (px_ovl_reg != 4'h0) begin
      colour = overlay_mem[px_ovl_reg];
    end else begin
      unique case (pdac_mode_t'(px_mode_reg))
        PDAC_MODE_TC24:
          colour = {pal_chan(px_r_reg, 0), pal_chan(px_g_reg, 1), pal_chan(px_b_reg, 2)};
        PDAC_MODE_TC15:
          colour = {pal_chan({px_r_reg[4:0], 3'h0}, 0), pal_chan({px_g_reg[4:0], 3'h0}, 1),
                    pal_chan({px_b_reg[4:0], 3'h0}, 2)};
        PDAC_MODE_TC8:
          colour = {pal_chan({px_r_reg[2:0], 5'h00}, 0), pal_chan({px_r_reg[5:3], 5'h00}, 1),
                    pal_chan({px_r_reg[7:6], 6'h00}, 2)};
        PDAC_MODE_PSEUDO8:
          colour = palette_mem[px_r_reg & read_mask_reg];
      endcase
    end
  end

  // Output stage: blank wins, sync only drops pedestal
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_red_code <= PDAC_BLANK_CODE;
      o_green_code <= PDAC_BLANK_CODE;
      o_blue_code <= PDAC_BLANK_CODE;
      o_sync_on <= 1'b1;
    end else begin
      if (!px_blank_n_reg) begin
        o_red_code <= PDAC_BLANK_CODE;
        o_green_code <= PDAC_BLANK_CODE;
        o_blue_code <= PDAC_BLANK_CODE;
      end else begin
        o_red_code <= colour[23:16];
        o_green_code <= colour[15:8];
        o_blue_code <= colour[7:0];
      end
      o_sync_on <= px_sync_n_reg;
    end
  end

endmodule

// *** dv/pdac_core_properties.sv ***
`timescale 1ns/10ps
// ----------------------
// Core port checker
// ----------------------
module pdac_core_properties
  import pdac_pkg::*;
(
  // Clock, reset, inputs
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_blank_n,
  input wire logic i_sync_n,
  input wire logic [3:0] i_overlay_select,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  // Outputs
  input wire logic [7:0] o_red_code,
  input wire logic [7:0] o_green_code,
  input wire logic [7:0] o_blue_code,
  input wire logic o_sync_on,
  input wire logic o_host_data_oe,
  input wire logic [7:0] o_general_control_outputs
);
  default clocking dcb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // All three codes as one word
  wire logic [23:0] code = {o_red_code, o_green_code, o_blue_code};

  a_blank_zero: assert property (!i_blank_n |-> ##2 code == 24'h00_0000)
    else $error("blanked pixel shows colour");
  a_ovl_steady: assert property ($past(i_nrst) && i_blank_n && $past(i_blank_n)
    && i_overlay_select != 4'h0 && $stable(i_overlay_select) |-> ##2 $stable(code))
    else $error("overlay colour moved");
  a_sync_on: assert property (i_sync_n |-> ##2 o_sync_on)
    else $error("pedestal off without sync");
  a_sync_off: assert property (!i_sync_n |-> ##2 !o_sync_on && code == 24'h00_0000)
    else $error("sync step wrong");
  a_ctl_steady: assert property (i_wr_n [*8] |-> $stable(o_general_control_outputs))
    else $error("control outputs moved without write");
  a_oe_idle: assert property (i_rd_n [*6] |-> !o_host_data_oe)
    else $error("bus driven outside read");
  a_oe_read: assert property (!i_rd_n [*8] |-> o_host_data_oe)
    else $error("bus not driven in read");
  a_oe_write: assert property (!i_wr_n [*4] |-> !o_host_data_oe)
    else $error("bus driven in write");

  c_overlay: cover property (i_blank_n && i_overlay_select != 4'h0);
  c_sync: cover property (!i_sync_n ##2 !o_sync_on);
  c_read: cover property ($rose(o_host_data_oe));
endmodule

bind pdac_core pdac_core_properties chk_u (
  .i_clk(i_clk),
  .i_nrst(i_nrst),
  .i_blank_n(i_blank_n),
  .i_sync_n(i_sync_n),
  .i_overlay_select(i_overlay_select),
  .i_wr_n(i_wr_n),
  .i_rd_n(i_rd_n),
  .o_red_code(o_red_code),
  .o_green_code(o_green_code),
  .o_blue_code(o_blue_code),
  .o_sync_on(o_sync_on),
  .o_host_data_oe(o_host_data_oe),
  .o_general_control_outputs(o_general_control_outputs)
);

// *** dv/pdac_host_model.sv ***
`timescale 1ns/10ps
// ----------------------
// Host processor model
// ----------------------
module pdac_host_model
  import pdac_pkg::*;
(
  // Clock and read data
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_oe,
  // Strobes, select, write data
  output logic o_wr_n,
  output logic o_rd_n,
  output logic [2:0] o_rs,
  output logic [7:0] o_wdata
);
  // Idle bus at time zero
  initial begin
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_rs = 3'h0;
    o_wdata = 8'h00;
  end

  // Select set before the fall, data held past the rise
  task automatic wr(input logic [2:0] rs, input logic [7:0] d);
    @(posedge i_clk);
    o_rs <= rs;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    o_wr_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    o_wdata <= ~d; // Released data stops showing the old value
    repeat (4) @(posedge i_clk);
  endtask

  // Strobe held low for ten clocks, then the bus is sampled
  task automatic rd(input logic [2:0] rs, output logic [7:0] d);
    @(posedge i_clk);
    o_rs <= rs;
    @(posedge i_clk);
    o_rd_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    d = i_rdata_oe ? i_rdata : ~i_rdata; // Undriven bus shows no valid byte
    o_rd_n <= 1'b1;
    repeat (10) @(posedge i_clk);
  endtask
endmodule

// *** dv/pdac_core_tb_top.sv ***
`timescale 1ns/10ps
// ----------------------
// Palette core bench
// ----------------------
module pdac_core_tb_top
  import pdac_pkg::*;
  ;
  // Pixel port drive
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] pr = 8'h00;
  logic [7:0] pg = 8'h00;
  logic [7:0] pb = 8'h00;
  logic [1:0] mode = 2'h0;
  logic [3:0] ovl = 4'h0;
  logic sync_n = 1'b1;
  logic blank_n = 1'b1;
  // Host port and outputs
  logic wr_n;
  logic rd_n;
  logic [2:0] rs;
  logic [7:0] wd;
  logic [7:0] rdat;
  logic rdoe;
  logic [7:0] cr;
  logic [7:0] cg;
  logic [7:0] cb;
  logic son;
  logic [7:0] ctl;
  // Reference model state
  logic [23:0] pal [256];
  logic [23:0] ovm [16];
  logic [24:0] expq [$];
  logic [23:0] e;
  logic pix_on = 1'b0;
  logic [15:0] seed = 16'hce18;
  logic [7:0] v8;
  logic [23:0] c24;
  int error_cnt = 0;
  int n_tests = 0;

  pdac_core dut_u (
    .i_clk(clk),
    .i_nrst(nrst),
    .i_red_pixel_in(pr),
    .i_green_pixel_in(pg),
    .i_blue_pixel_in(pb),
    .i_color_mode_select(mode),
    .i_overlay_select(ovl),
    .i_sync_n(sync_n),
    .i_blank_n(blank_n),
    .i_wr_n(wr_n),
    .i_rd_n(rd_n),
    .i_register_select(rs),
    .i_host_data_bus(wd),
    .o_host_data_bus(rdat),
    .o_host_data_oe(rdoe),
    .o_red_code(cr),
    .o_green_code(cg),
    .o_blue_code(cb),
    .o_sync_on(son),
    .o_general_control_outputs(ctl)
  );
  pdac_host_model host_u (
    .i_clk(clk),
    .i_rdata(rdat),
    .i_rdata_oe(rdoe),
    .o_wr_n(wr_n),
    .o_rd_n(rd_n),
    .o_rs(rs),
    .o_wdata(wd)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    for (int i = 0; i < 16; i++) begin
      s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    end
    return s;
  endfunction

  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One palette entry, address first
  task automatic pal_set(input logic [7:0] a, input logic [23:0] c);
    host_u.wr(PDAC_RS_ADDR_WR, a);
    for (int k = 2; k >= 0; k--) begin
      host_u.wr(PDAC_RS_PAL_DATA, c[8*k+:8]);
    end
    pal[a] = c;
  endtask

  // Red, green, blue read of one entry
  task automatic rd3(input logic [2:0] s, output logic [23:0] c);
    for (int k = 2; k >= 0; k--) begin
      host_u.rd(s, c[8*k+:8]);
    end
  endtask

  // Predict each pixel, compare two edges after it is taken
  always @(posedge clk) begin
    if (!pix_on) begin
      expq.delete();
    end else begin
      // Palette indices per colour mode
      case (mode)
        PDAC_MODE_TC15:
          e = {pal[{pr[4:0], 3'h0}][23:16], pal[{pg[4:0], 3'h0}][15:8],
               pal[{pb[4:0], 3'h0}][7:0]};
        PDAC_MODE_TC8:
          e = {pal[{pr[2:0], 5'h00}][23:16], pal[{pr[5:3], 5'h00}][15:8],
               pal[{pr[7:6], 6'h00}][7:0]};
        PDAC_MODE_PSEUDO8:
          e = pal[pr];
        default:
          e = {pal[pr][23:16], pal[pg][15:8], pal[pb][7:0]};
      endcase
      if (ovl != 4'h0) e = ovm[ovl];
      if (!blank_n) e = 24'h00_0000;
      expq.push_back({sync_n, e});
      if (expq.size() == 3) chk({son, cr, cg, cb}, expq.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(25'(ctl), 25'(PDAC_RST_COMMAND));
    host_u.rd(PDAC_RS_READ_MASK, v8);
    chk(25'(v8), 25'(PDAC_RST_READ_MASK));
    // Identity palette from one start address
    host_u.wr(PDAC_RS_ADDR_WR, 8'h00);
    for (int i = 0; i < 256; i++) begin
      pal[i] = {3{8'(i)}};
      for (int k = 0; k < 3; k++) begin
        host_u.wr(PDAC_RS_PAL_DATA, 8'(i));
      end
    end
    // Byte order, reload and wrap of the address
    pal_set(8'hff, 24'ha1_b2c3);
    host_u.wr(PDAC_RS_ADDR_RD, 8'hfe);
    for (int a = 254; a < 257; a++) begin
      rd3(PDAC_RS_PAL_DATA, c24);
      chk(25'(c24), 25'(pal[a % 256]));
    end
    pal_set(8'hff, 24'hff_ffff);
    // Overlay slots 1 to 15
    host_u.wr(PDAC_RS_OVL_ADDR_WR, 8'h01);
    for (int s = 1; s < 16; s++) begin
      ovm[s] = {4'h1, 4'(s), 4'h2, 4'(s), 4'h3, 4'(s)};
      for (int k = 2; k >= 0; k--) begin
        host_u.wr(PDAC_RS_OVL_DATA, ovm[s][8*k+:8]);
      end
    end
    host_u.wr(PDAC_RS_OVL_ADDR_RD, 8'h03);
    for (int s = 3; s < 5; s++) begin
      rd3(PDAC_RS_OVL_DATA, c24);
      chk(25'(c24), 25'(ovm[s]));
    end
    // Command and mask registers
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      host_u.wr(PDAC_RS_COMMAND, seed[7:0]);
      chk(25'(ctl), 25'(seed[7:0]));
      host_u.rd(PDAC_RS_COMMAND, v8);
      chk(25'(v8), 25'(seed[7:0]));
      host_u.wr(PDAC_RS_READ_MASK, seed[15:8]);
      host_u.rd(PDAC_RS_READ_MASK, v8);
      chk(25'(v8), 25'(seed[15:8]));
    end
    host_u.wr(PDAC_RS_READ_MASK, 8'hff);
    // Random pixels every clock
    pix_on <= 1'b1;
    repeat (3000) begin
      @(posedge clk);
      seed = lfsr(seed);
      pr <= seed[7:0];
      pg <= seed[15:8];
      seed = lfsr(seed);
      pb <= seed[7:0];
      ovl <= seed[8] ? seed[12:9] : 4'h0;
      mode <= seed[11:10];
      blank_n <= seed[15:13] != 3'h0;
      sync_n <= !(seed[15:13] == 3'h0 && seed[0]);
    end
    pix_on <= 1'b0;
    @(posedge clk);
    results();
  end
endmodule
